// ==== hdl/ssirq_map.svh ====
`ifndef SSIRQ_MAP_SVH
`define SSIRQ_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define SSIRQ_OFF_STATUS  8'h00
`define SSIRQ_OFF_IRQ_EN  8'h04
`define SSIRQ_OFF_IRQ_DIS 8'h08
`define SSIRQ_OFF_MASK    8'h0c
`define SSIRQ_OFF_CTRL    8'h10
// ==========================================
// Status bit positions, and the control register edge select bit
`define SSIRQ_B_HOLD_FREE 0
`define SSIRQ_B_ALL_SENT  1
`define SSIRQ_B_TX_DONE   2
`define SSIRQ_B_TX_ZERO   3
`define SSIRQ_B_RX_AVAIL  4
`define SSIRQ_B_OVERRUN   5
`define SSIRQ_B_RX_DONE   6
`define SSIRQ_B_RX_ZERO   7
`define SSIRQ_B_MATCH1    8
`define SSIRQ_B_MATCH2    9
`define SSIRQ_B_TX_SYNC   10
`define SSIRQ_B_RX_SYNC   11
`define SSIRQ_B_TX_ON     16
`define SSIRQ_B_RX_ON     17
`define SSIRQ_B_EDGE_SEL  0
// ==========================================
// Reset values, and the mask of sticky status bits
`define SSIRQ_RST_MASK    12'h000
`define SSIRQ_RST_EDGE    1'h0
`define SSIRQ_STICKY      12'hf20
`endif

// ==== hdl/ssirq_pkg.sv ====
package ssirq_pkg;
  // ==========================================
  // Whole block state
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [11:0] flags;
    logic [11:0] mask;
    logic        edge_sel;
    logic        tx_on;
    logic        rx_on;
    logic [1:0]  lclk_s;
    logic        lclk_prev;
    logic [1:0]  txfs_s;
    logic [1:0]  rxfs_s;
    logic        txfs_smp;
    logic        rxfs_smp;
    logic        irq;
  } ssirq_state_t;
endpackage

// ==== hdl/ssirq_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// [RL1] Bit 0 reads 0 while a word waits in holding register, else 1.
// [RL2] Bit 1 set only when holding register and shift register are both drained.
// [RL3] Bit 2 sets when tx counter reaches zero; tx counter write clears it.
// [RL4] Bit 3 is 1 only when both tx counters are zero.
// [RL5] Bit 4 shows an unread word in the receive holding register.
// [RL6] Bit 5 sets on load over unread word; status read clears it.
// [RL7] Bit 6 sets when rx counter reaches zero; rx counter write clears it.
// [RL8] Bit 7 is 1 only when both rx counters are zero.
// [RL9] Bits 8 and 9 latch compare matches until status read.
// [RL10] Bits 10 and 11 latch frame sync events until status read.
// [RL11] Bits 16 and 17 show transmitter and receiver enabled.
// [RL12] Ones written to enable register set mask bits; zeros do nothing.
// [RL13] Ones written to disable register clear mask bits; zeros do nothing.
// [RL14] Mask register reads enable state at the status bit positions.
// [RL15] Edge select bit: 0 rising, 1 falling frame sync raises tx sync.
// [RL16] Interrupt output high while any enabled status flag is set.
// [RL17] All mask bits clear at reset.
`include "ssirq_map.svh"

module ssirq_top
  import ssirq_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  input  wire logic             tx_holding_full_i,
  input  wire logic             tx_shift_busy_i,
  input  wire logic [CNT_W-1:0] tx_dma_counter_i,
  input  wire logic [CNT_W-1:0] tx_dma_next_counter_i,
  input  wire logic             tx_cnt_write_i,
  input  wire logic             rx_load_i,
  input  wire logic             rx_read_i,
  input  wire logic [CNT_W-1:0] rx_dma_counter_i,
  input  wire logic [CNT_W-1:0] rx_dma_next_counter_i,
  input  wire logic             rx_cnt_write_i,
  input  wire logic             rx_match_first_i,
  input  wire logic             rx_match_second_i,
  input  wire logic             tx_on_i,
  input  wire logic             rx_on_i,
  input  wire logic             link_clk_i,
  input  wire logic             tx_frame_sync_i,
  input  wire logic             rx_frame_sync_i
);

  ssirq_state_t s_reg;
  ssirq_state_t s_next;

  // ==========================================
  // Status word assembly
  function automatic logic [31:0] status_word(input ssirq_state_t st);
    logic [31:0] w;
    w = 32'h0;
    w[11:0] = st.flags;
    w[`SSIRQ_B_TX_ON] = st.tx_on;  // see [RL11]
    w[`SSIRQ_B_RX_ON] = st.rx_on;  // see [RL11]
    return w;
  endfunction

  // Byte lanes to a 12-bit write mask
  function automatic logic [11:0] lane_bits(input logic [3:0] sel,
                                            input logic [31:0] d);
    return d[11:0] & {{4{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ==========================================
  // Next-state logic
  always_comb begin
    logic        req;
    logic        rd_stat;
    logic        wr;
    logic [11:0] wbits;
    logic [11:0] clr;
    logic [11:0] set;
    logic        link_rise;
    logic        tx_evt;
    logic        rx_evt;
    req = 1'b0;
    rd_stat = 1'b0;
    wr = 1'b0;
    wbits = 12'h000;
    clr = 12'h000;
    set = 12'h000;
    link_rise = 1'b0;
    tx_evt = 1'b0;
    rx_evt = 1'b0;
    s_next = s_reg;
    if (ce_i) begin
      // Pin synchronisers; stage 0 feeds stage 1 only
      s_next.lclk_s = {s_reg.lclk_s[0], link_clk_i};
      s_next.txfs_s = {s_reg.txfs_s[0], tx_frame_sync_i};
      s_next.rxfs_s = {s_reg.rxfs_s[0], rx_frame_sync_i};
      s_next.lclk_prev = s_reg.lclk_s[1];
      link_rise = s_reg.lclk_s[1] & ~s_reg.lclk_prev;
      // Frame sync sampled on link clock rising edges
      if (link_rise) begin
        s_next.txfs_smp = s_reg.txfs_s[1];
        s_next.rxfs_smp = s_reg.rxfs_s[1];
        tx_evt = s_reg.edge_sel ? (s_reg.txfs_smp & ~s_reg.txfs_s[1])
                                : (~s_reg.txfs_smp & s_reg.txfs_s[1]);  // see [RL15]
        rx_evt = ~s_reg.rxfs_smp & s_reg.rxfs_s[1];
      end

      // Classic Wishbone: one wait state, ack drops after one cycle
      req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      wr = req & wb_we_i;
      wbits = lane_bits(wb_sel_i, wb_dat_i);
      s_next.ack = req;
      s_next.rdat = 32'h0;
      if (req & ~wb_we_i) begin
        case (wb_adr_i)
          `SSIRQ_OFF_STATUS: begin
            s_next.rdat = status_word(s_reg);
            rd_stat = 1'b1;
          end
          `SSIRQ_OFF_MASK: s_next.rdat = {20'h0, s_reg.mask};  // see [RL14]
          `SSIRQ_OFF_CTRL: s_next.rdat = {31'h0, s_reg.edge_sel};
          default: s_next.rdat = 32'h0;
        endcase
      end

      // Mask enable and disable writes, zeros leave bits alone
      if (wr && wb_adr_i == `SSIRQ_OFF_IRQ_EN) begin
        s_next.mask = s_reg.mask | wbits;  // see [RL12]
      end
      if (wr && wb_adr_i == `SSIRQ_OFF_IRQ_DIS) begin
        s_next.mask = s_reg.mask & ~wbits;  // see [RL13]
      end
      if (wr && wb_adr_i == `SSIRQ_OFF_CTRL && wb_sel_i[0]) begin
        s_next.edge_sel = wb_dat_i[`SSIRQ_B_EDGE_SEL];
      end

      // Sticky bits clear on status read, or by writing ones to it
      if (rd_stat) begin
        clr = `SSIRQ_STICKY;  // see [RL6] [RL9] [RL10]
      end
      if (wr && wb_adr_i == `SSIRQ_OFF_STATUS) begin
        clr = wbits & `SSIRQ_STICKY;
      end
      set[`SSIRQ_B_OVERRUN] = rx_load_i & s_reg.flags[`SSIRQ_B_RX_AVAIL]
                              & ~rx_read_i;  // see [RL6]
      set[`SSIRQ_B_MATCH1]  = rx_match_first_i;   // see [RL9]
      set[`SSIRQ_B_MATCH2]  = rx_match_second_i;  // see [RL9]
      set[`SSIRQ_B_TX_SYNC] = tx_evt;             // see [RL10]
      set[`SSIRQ_B_RX_SYNC] = rx_evt;             // see [RL10]
      // Set wins so an event in the clearing cycle is kept
      s_next.flags = (s_reg.flags & ~clr) | (set & `SSIRQ_STICKY);

      // Level flags follow the transmit and receive paths
      s_next.flags[`SSIRQ_B_HOLD_FREE] = ~tx_holding_full_i;  // see [RL1]
      s_next.flags[`SSIRQ_B_ALL_SENT] = ~tx_holding_full_i
                                        & ~tx_shift_busy_i;  // see [RL2]
      s_next.flags[`SSIRQ_B_TX_ZERO] = (tx_dma_counter_i == '0)
                                       & (tx_dma_next_counter_i == '0);  // see [RL4]
      s_next.flags[`SSIRQ_B_RX_ZERO] = (rx_dma_counter_i == '0)
                                       & (rx_dma_next_counter_i == '0);  // see [RL8]
      // Load wins over a read in the same cycle
      s_next.flags[`SSIRQ_B_RX_AVAIL] = rx_load_i
        | (s_reg.flags[`SSIRQ_B_RX_AVAIL] & ~rx_read_i);  // see [RL5]
      // Counter write clears; the old count seen that cycle is stale
      s_next.flags[`SSIRQ_B_TX_DONE] = ~tx_cnt_write_i
        & (s_reg.flags[`SSIRQ_B_TX_DONE] | (tx_dma_counter_i == '0));  // see [RL3]
      s_next.flags[`SSIRQ_B_RX_DONE] = ~rx_cnt_write_i
        & (s_reg.flags[`SSIRQ_B_RX_DONE] | (rx_dma_counter_i == '0));  // see [RL7]
      s_next.tx_on = tx_on_i;  // see [RL11]
      s_next.rx_on = rx_on_i;  // see [RL11]

      // Interrupt from the new flags and mask, so it is a flop output
      s_next.irq = |(s_next.flags & s_next.mask);  // see [RL16]
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.mask <= `SSIRQ_RST_MASK;  // see [RL17]
      s_reg.edge_sel <= `SSIRQ_RST_EDGE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.rdat;
  assign wb_ack_o = s_reg.ack;
  assign irq_o = s_reg.irq;

  // ==========================================
  // Checks
  sequence q_req(logic [7:0] a, logic w);
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i == w && wb_adr_i == a;
  endsequence

  property p_hold_free;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> s_reg.flags[0] == !$past(tx_holding_full_i);
  endproperty
  a_hold_free: assert property (p_hold_free) else $error("holding flag wrong");  // see [RL1]

  property p_all_sent;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && (tx_holding_full_i || tx_shift_busy_i) |=> !s_reg.flags[1];
  endproperty
  a_all_sent: assert property (p_all_sent) else $error("sent flag early");  // see [RL2]

  property p_tx_done;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && tx_cnt_write_i |=> !s_reg.flags[2];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done not cleared");  // see [RL3]

  property p_overrun;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_load_i && s_reg.flags[4] && !rx_read_i |=> s_reg.flags[5];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");  // see [RL6]

  property p_rx_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_dma_next_counter_i != '0 |=> !s_reg.flags[7];
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("rx zero wrong");  // see [RL8]

  property p_read_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_req(`SSIRQ_OFF_STATUS, 1'b0) ##0 !rx_match_first_i
      |=> wb_ack_o && !s_reg.flags[8];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("match not cleared");  // see [RL9]

  property p_enable;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_req(`SSIRQ_OFF_IRQ_EN, 1'b1) ##0 wb_sel_i[0] && wb_dat_i[0]
      |=> s_reg.mask[0] ##1 !wb_ack_o;
  endproperty
  a_enable: assert property (p_enable) else $error("enable failed");  // see [RL12]

  property p_disable;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_req(`SSIRQ_OFF_IRQ_DIS, 1'b1) ##0 wb_sel_i[0] && wb_dat_i[4]
      |=> !s_reg.mask[4];
  endproperty
  a_disable: assert property (p_disable) else $error("disable failed");  // see [RL13]

  property p_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    irq_o == |(s_reg.flags & s_reg.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");  // see [RL16]

  // Link clock rising edge as the synchroniser sees it
  sequence q_link_rise;
    ce_i && s_reg.lclk_s[1] && !s_reg.lclk_prev;
  endsequence

  property p_all_sent_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !tx_holding_full_i && !tx_shift_busy_i |=> s_reg.flags[1];
  endproperty
  a_all_sent_set: assert property (p_all_sent_set) else $error("sent flag late");  // see [RL2]

  // Done flag re-sets every cycle the count sits at zero without a counter write
  property p_tx_done_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !tx_cnt_write_i && tx_dma_counter_i == '0 |=> s_reg.flags[2];
  endproperty
  a_tx_done_set: assert property (p_tx_done_set) else $error("tx done missed");  // see [RL3]

  property p_tx_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && (tx_dma_counter_i != '0 || tx_dma_next_counter_i != '0) |=> !s_reg.flags[3];
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("tx zero early");  // see [RL4]

  property p_tx_zero_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && tx_dma_counter_i == '0 && tx_dma_next_counter_i == '0 |=> s_reg.flags[3];
  endproperty
  a_tx_zero_set: assert property (p_tx_zero_set) else $error("tx zero missed");  // see [RL4]

  property p_rx_avail;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_load_i |=> s_reg.flags[4];
  endproperty
  a_rx_avail: assert property (p_rx_avail) else $error("rx word missed");  // see [RL5]

  property p_rx_avail_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_read_i && !rx_load_i |=> !s_reg.flags[4];
  endproperty
  a_rx_avail_clr: assert property (p_rx_avail_clr) else $error("rx word stuck");  // see [RL5]

  property p_rx_done;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_cnt_write_i |=> !s_reg.flags[6];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("rx done not cleared");  // see [RL7]

  property p_rx_done_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !rx_cnt_write_i && rx_dma_counter_i == '0 |=> s_reg.flags[6];
  endproperty
  a_rx_done_set: assert property (p_rx_done_set) else $error("rx done missed");  // see [RL7]

  property p_match2;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && rx_match_second_i |=> s_reg.flags[9];
  endproperty
  a_match2: assert property (p_match2) else $error("match two missed");  // see [RL9]

  property p_rx_sync;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_link_rise ##0 (!s_reg.rxfs_smp && s_reg.rxfs_s[1]) |=> s_reg.flags[11];
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx sync missed");  // see [RL10]

  // Both edge choices checked, so a swapped select is caught
  property p_tx_sync_rise;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_link_rise ##0 (!s_reg.edge_sel && !s_reg.txfs_smp && s_reg.txfs_s[1])
      |=> s_reg.flags[10];
  endproperty
  a_tx_sync_rise: assert property (p_tx_sync_rise) else $error("tx sync rise missed");  // see [RL15]

  property p_tx_sync_fall;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_link_rise ##0 (s_reg.edge_sel && s_reg.txfs_smp && !s_reg.txfs_s[1])
      |=> s_reg.flags[10];
  endproperty
  a_tx_sync_fall: assert property (p_tx_sync_fall) else $error("tx sync fall missed");  // see [RL15]

  property p_on_state;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> s_reg.tx_on == $past(tx_on_i) && s_reg.rx_on == $past(rx_on_i);
  endproperty
  a_on_state: assert property (p_on_state) else $error("enable state wrong");  // see [RL11]

  property p_mask_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    q_req(`SSIRQ_OFF_MASK, 1'b0) |=> wb_dat_o == {20'h0, $past(s_reg.mask)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");  // see [RL14]

  // No disable here: the reset itself is what is watched
  property p_reset_mask;
    @(posedge sys_clk_i)
    rst_i |=> s_reg.mask == 12'h000 && !irq_o;
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("mask not cleared");  // see [RL17]

  // Clock enable low freezes everything, synchronisers included
  property p_freeze;
    @(posedge sys_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(s_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule

// ==== verification/ssirq_peer.sv ====
`timescale 1ns/100ps
// ==========================================
// Serial peer: link clock and frame sync pins
module ssirq_peer (
  input  wire logic frame_i,
  input  wire logic tx_want_i,
  input  wire logic rx_want_i,
  output logic      link_clk_o,
  output logic      tx_fs_o,
  output logic      rx_fs_o
);
  // Clock stands still low between frames; pins move on falling edges
  // so they are stable across every rising edge the block samples
  initial begin
    link_clk_o = 1'b0;
    tx_fs_o    = 1'b0;
    rx_fs_o    = 1'b0;
    forever begin
      wait (frame_i);
      #100 link_clk_o = 1'b1;
      #100 link_clk_o = 1'b0;
      tx_fs_o = tx_want_i;
      rx_fs_o = rx_want_i;
    end
  end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`include "ssirq_map.svh"
module testbench;
  logic        clk, rst, cyc, stb, we, ack, irq, hold, busy, ton, ron;
  logic        frame, txwant, rxwant, lclk, txfs, rxfs, ce;
  logic [5:0]  pls;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] txc, txn, rxc, rxn;
  int          num_errors, checks;

  // ==========================================
  // Design and peer
  ssirq_top dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .tx_holding_full_i(hold), .tx_shift_busy_i(busy),
    .tx_dma_counter_i(txc), .tx_dma_next_counter_i(txn), .tx_cnt_write_i(pls[0]),
    .rx_load_i(pls[2]), .rx_read_i(pls[3]), .rx_dma_counter_i(rxc),
    .rx_dma_next_counter_i(rxn), .rx_cnt_write_i(pls[1]), .rx_match_first_i(pls[4]),
    .rx_match_second_i(pls[5]), .tx_on_i(ton), .rx_on_i(ron), .link_clk_i(lclk),
    .tx_frame_sync_i(txfs), .rx_frame_sync_i(rxfs));
  ssirq_peer peer (.frame_i(frame), .tx_want_i(txwant), .rx_want_i(rxwant),
    .link_clk_o(lclk), .tx_fs_o(txfs), .rx_fs_o(rxfs));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // Tasks
  task automatic final_report;
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic cycle; bounded wait so a missing ack ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin num_errors++; final_report(); end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // One-cycle pulse on the flag inputs, then let it land
  task automatic pulse(input logic [5:0] p);
    @(posedge clk); pls <= p;
    @(posedge clk); pls <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    num_errors = 0; checks = 0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; wdat = 32'h0; pls = 6'h00; hold = 1'b0; busy = 1'b0; ton = 1'b1;
    ron = 1'b0; txc = 16'h0005; txn = 16'h0005; rxc = 16'h0005; rxn = 16'h0005;
    frame = 1'b0; txwant = 1'b0; rxwant = 1'b0; ce = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`SSIRQ_OFF_MASK, 32'h0);
    rdc(`SSIRQ_OFF_STATUS, 32'h0001_0003);
    @(posedge clk);
    hold <= 1'b1; busy <= 1'b1; txc <= 16'h0; txn <= 16'h0; rxc <= 16'h0; rxn <= 16'h3;
    ton <= 1'b0; ron <= 1'b1;
    settle();
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_004c);
    @(posedge clk);
    hold <= 1'b0; txc <= 16'h7; rxc <= 16'h2;
    pulse(6'h03);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0001);
    // Mask set, clear, no-op write, unmapped read
    bus(1'b1, `SSIRQ_OFF_IRQ_EN, 32'h0000_0fff);
    rdc(`SSIRQ_OFF_MASK, 32'h0000_0fff);
    settle();
    chk(irq, 1'b1);
    bus(1'b1, `SSIRQ_OFF_IRQ_DIS, 32'h0000_00a5);
    bus(1'b1, `SSIRQ_OFF_IRQ_EN, 32'h0);
    rdc(`SSIRQ_OFF_MASK, 32'h0000_0f5a);
    settle();
    chk(irq, 1'b0);
    rdc(8'h20, 32'h0);
    // Sticky events: overrun, compare matches
    pulse(6'h04);
    pulse(6'h04);
    pulse(6'h30);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0331);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0011);
    chk(irq, 1'b1);
    pulse(6'h08);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0001);
    settle();
    chk(irq, 1'b0);
    // Frame sync events over the link
    @(posedge clk);
    frame <= 1'b1; txwant <= 1'b1; rxwant <= 1'b1;
    repeat (40) @(posedge clk);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0c01);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0001);
    bus(1'b1, `SSIRQ_OFF_CTRL, 32'h1);
    rdc(`SSIRQ_OFF_CTRL, 32'h1);
    txwant <= 1'b0; rxwant <= 1'b0;
    repeat (40) @(posedge clk);
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0401);
    frame <= 1'b0;
    // Clock enable low: a match pulse must be ignored
    @(posedge clk); ce <= 1'b0;
    pulse(6'h10);
    @(posedge clk); ce <= 1'b1;
    rdc(`SSIRQ_OFF_STATUS, 32'h0002_0001);
    bus(1'b1, `SSIRQ_OFF_IRQ_DIS, 32'h0000_0fff);
    rdc(`SSIRQ_OFF_MASK, 32'h0);
    final_report();
  end
endmodule
